// ### hdl/dsr_regs.svh
// register offsets, field positions, reset values and answer codes of the drive
// serial register map; assumes 16-bit registers addressed by 16-bit numbers
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

// ******************************
// register numbers
// ******************************
`define DSR_ADDR_OP_SIGNAL 16'h0001
`define DSR_ADDR_FREQ_REF 16'h0002
`define DSR_ADDR_DOUT_STATUS 16'h002D
`define DSR_ADDR_DC_BUS 16'h0031
`define DSR_ADDR_TORQUE_POWER 16'h0032
`define DSR_ADDR_PID_FEEDBACK 16'h0038
`define DSR_ADDR_PID_INPUT 16'h0039
`define DSR_ADDR_PID_OUTPUT 16'h003A
`define DSR_ADDR_CPU_SW 16'h003B
`define DSR_ADDR_FLASH_SW 16'h003C
`define DSR_ADDR_COMM_ERR 16'h003D
`define DSR_ADDR_POWER_RATING 16'h003E
`define DSR_ADDR_CONTROL_METHOD 16'h003F
`define DSR_ADDR_COMMIT_NV 16'h0900
`define DSR_ADDR_COMMIT_RAM 16'h0910
`define DSR_ADDR_PARAM_BASE 16'h0100

// ******************************
// field positions
// ******************************
`define DSR_OP_RUN 0
`define DSR_OP_REVERSE 1
`define DSR_OP_EXT_FAULT 4
`define DSR_OP_FAULT_RESET 5
`define DSR_OP_DIN_LSB 12
`define DSR_OP_DEFINED_MASK 16'hF033
`define DSR_DOUT_LSB 1
`define DSR_ERR_CRC 0
`define DSR_ERR_LENGTH 1
`define DSR_ERR_PARITY 3
`define DSR_ERR_OVERRUN 4
`define DSR_ERR_FRAMING 5
`define DSR_ERR_TIMEOUT 6

// ******************************
// reset values and codes
// ******************************
`define DSR_OP_RESET 16'h0000
`define DSR_FREQ_RESET 16'h0000
`define DSR_PARAM_RESET 16'h0000
`define DSR_COMMIT_VALUE 16'h0000
`define DSR_CODE_NONE 8'h00
`define DSR_CODE_BAD_ADDR 8'h02
`define DSR_CODE_BAD_DATA 8'h21
`define DSR_CODE_WRITE_MODE 8'h22
`define DSR_CODE_BUSY 8'h24

`endif

// ### hdl/dsr_pkg.sv
// shared types of the drive serial register map
// assumes the constants header is included by each user
package dsr_pkg;

  // ******************************
  // register kinds after decode
  // ******************************
  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_OP = 3'b001,
    KIND_FREQ = 3'b010,
    KIND_MON = 3'b011,
    KIND_COMMIT_NV = 3'b100,
    KIND_COMMIT_RAM = 3'b101,
    KIND_PARAM = 3'b110
  } dsr_kind_e;

  // ******************************
  // commit walker states
  // ******************************
  typedef enum logic [0:0] {
    COMMIT_IDLE = 1'b0,
    COMMIT_COPY = 1'b1
  } dsr_commit_e;

endpackage

// ### hdl/dsr_err_latch.sv
// sticky communication error detail word
// assumes error events are one-cycle pulses on clk from the link receiver
`timescale 1ns/100ps
`include "dsr_regs.svh"

module dsr_err_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] errEvent,
  input wire logic clear,
  output logic [15:0] errDetail
);

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [15:0] detail; // latched error bits
  } dsr_latch_s;

  // event slot to bit position: crc, length, parity, overrun, framing, time-out
  localparam int BIT_POS [6] = '{`DSR_ERR_CRC, `DSR_ERR_LENGTH, `DSR_ERR_PARITY,
                                 `DSR_ERR_OVERRUN, `DSR_ERR_FRAMING, `DSR_ERR_TIMEOUT};

  dsr_latch_s st_reg;
  dsr_latch_s st_next;

  // ******************************
  // next state
  // ******************************
  // clear first, then set: a new error in the clearing cycle survives
  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.detail = 16'h0000;
    end
    for (int i = 0; i < 6; i++) begin
      if (errEvent[i]) begin
        st_next.detail[BIT_POS[i]] = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign errDetail = st_reg.detail;

endmodule

// ### hdl/dsr_commit_ctrl.sv
// walker that copies staged parameters one word per cycle
// assumes start pulses come only while busy is low
`timescale 1ns/100ps

module dsr_commit_ctrl #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic startNv,
  input wire logic startRam,
  output logic busy,
  output logic copyEn,
  output logic [IDX_W-1:0] copyIdx,
  output logic toEeprom,
  output logic done
);

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    dsr_pkg::dsr_commit_e fsm; // idle or copying
    logic [IDX_W-1:0] idx; // word being copied
    logic nv; // also store to eeprom
    logic done; // last word copied
  } dsr_commit_s;

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);

  dsr_commit_s st_reg;
  dsr_commit_s st_next;

  // ******************************
  // next state
  // ******************************
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.fsm)
      dsr_pkg::COMMIT_IDLE: begin
        // a start while copying would tear the active set, so only idle starts
        if (startNv || startRam) begin
          st_next.fsm = dsr_pkg::COMMIT_COPY;
          st_next.idx = '0;
          st_next.nv = startNv;
        end
      end
      dsr_pkg::COMMIT_COPY: begin
        if (st_reg.idx == LAST_IDX) begin
          st_next.fsm = dsr_pkg::COMMIT_IDLE;
          st_next.done = 1'b1;
        end else begin
          st_next.idx = st_reg.idx + 1'b1;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = (st_reg.fsm == dsr_pkg::COMMIT_COPY);
  assign copyEn = busy;
  assign copyIdx = st_reg.idx;
  assign toEeprom = st_reg.nv;
  assign done = st_reg.done;

endmodule

// ### hdl/dsr_register_map.sv
// slave-side register map of the drive serial interface
// assumes a framer on clk that hands over one decoded register access at a time
// and that all monitor and event inputs come from logic on clk
`timescale 1ns/100ps
`include "dsr_regs.svh"

// How it works
// - output status bits 1-4 mirror transistor outputs
// - error detail bits set per error kind
// - error bits stay until fault reset clears
// - operation bits 0,1 give run and reverse
// - operation bits 4,5 give fault and reset
// - operation bits C-F drive digital inputs 5-8
// - undefined operation bits use local node values
// - operation and frequency registers are read-write
// - written parameters wait in staging area
// - master writes zero to commit register
// - first commit also stores eeprom, second RAM only
// - reading commit registers answers code two
// - PID feedback unsigned, input/output signed, 10 per percent
// - address-zero writes to operation and frequency execute, all without any answer
module dsr_register_map #(
  parameter int PARAM_DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  // register access from the message framer
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqBroadcast,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqWdata,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspError,
  output logic [7:0] rspErrorCode,
  // monitored quantities
  input wire logic [3:0] transistorOutput,
  input wire logic [15:0] dcBusVoltage,
  input wire logic [15:0] torqueValue,
  input wire logic [15:0] outputPowerValue,
  input wire logic outputPowerDisplayItem,
  input wire logic [15:0] pidFeedback,
  input wire logic signed [15:0] pidInput,
  input wire logic signed [15:0] pidOutput,
  input wire logic [15:0] cpuSoftwareNumber,
  input wire logic [15:0] flashSoftwareNumber,
  input wire logic [15:0] powerRating,
  input wire logic [15:0] controlMethod,
  // link error events and local signals
  input wire logic [5:0] commErrEvent,
  input wire logic faultResetIn,
  input wire logic [15:0] localOpSignal,
  // drive-side command outputs
  output logic [15:0] opSignal,
  output logic runCommand,
  output logic reverseCommand,
  output logic externalFault,
  output logic faultResetCommand,
  output logic [3:0] digitalInputFiveToEight,
  output logic [15:0] frequencyReference,
  // parameter store
  output logic [PARAM_DEPTH*16-1:0] paramActive,
  output logic commitBusy,
  output logic commitDone,
  output logic eepromWrite,
  output logic [IDX_W-1:0] eepromAddr,
  output logic [15:0] eepromData
);

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [15:0] opReg; // broadcast operation signal as written
    logic [15:0] freqReg; // broadcast frequency reference
    logic [15:0] opMerged; // written bits merged with local bits
    logic [PARAM_DEPTH-1:0][15:0] stage; // staged parameter words
    logic [PARAM_DEPTH-1:0][15:0] active; // parameters in effect
    logic rspValid; // answer strobe
    logic [15:0] rspData; // read data, zero on error
    logic [7:0] rspCode; // answer code
    logic faultPulse; // fault reset, one cycle
    logic eepromWe; // eeprom store strobe
    logic [IDX_W-1:0] eepromAddr; // word being stored
    logic [15:0] eepromData; // value being stored
  } dsr_map_s;

  dsr_map_s st_reg;
  dsr_map_s st_next;

  logic [15:0] errDetail; // sticky error bits
  logic startNv; // commit with eeprom store
  logic startRam; // commit to RAM only
  logic busy; // commit walk running
  logic copyEn; // copy one word this cycle
  logic [IDX_W-1:0] copyIdx; // word to copy
  logic toEeprom; // walk also stores eeprom
  logic walkDone; // walk finished

  // ******************************
  // decode
  // ******************************
  // used by both the read and the write path so they can never disagree
  function automatic dsr_pkg::dsr_kind_e decodeKind(input logic [15:0] a);
    logic [15:0] off;
    off = a - `DSR_ADDR_PARAM_BASE;
    if (a == `DSR_ADDR_OP_SIGNAL) begin
      return dsr_pkg::KIND_OP;
    end else if (a == `DSR_ADDR_FREQ_REF) begin
      return dsr_pkg::KIND_FREQ;
    end else if (a == `DSR_ADDR_COMMIT_NV) begin
      return dsr_pkg::KIND_COMMIT_NV;
    end else if (a == `DSR_ADDR_COMMIT_RAM) begin
      return dsr_pkg::KIND_COMMIT_RAM;
    end else if (a >= `DSR_ADDR_PARAM_BASE && off < 16'(PARAM_DEPTH)) begin
      return dsr_pkg::KIND_PARAM;
    end
    // gaps inside the monitor block are unmapped
    unique case (a)
      `DSR_ADDR_DOUT_STATUS, `DSR_ADDR_DC_BUS, `DSR_ADDR_TORQUE_POWER,
      `DSR_ADDR_PID_FEEDBACK, `DSR_ADDR_PID_INPUT, `DSR_ADDR_PID_OUTPUT,
      `DSR_ADDR_CPU_SW, `DSR_ADDR_FLASH_SW, `DSR_ADDR_COMM_ERR,
      `DSR_ADDR_POWER_RATING, `DSR_ADDR_CONTROL_METHOD: return dsr_pkg::KIND_MON;
      default: return dsr_pkg::KIND_NONE;
    endcase
  endfunction

  // monitor read mux, all sixteen bits wide
  function automatic logic [15:0] monRead(input logic [15:0] a);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      `DSR_ADDR_DOUT_STATUS: d[`DSR_DOUT_LSB +: 4] = transistorOutput;
      `DSR_ADDR_DC_BUS: d = dcBusVoltage;
      // one number, two quantities: the display item picks which
      `DSR_ADDR_TORQUE_POWER: d = outputPowerDisplayItem ? outputPowerValue : torqueValue;
      `DSR_ADDR_PID_FEEDBACK: d = pidFeedback;
      `DSR_ADDR_PID_INPUT: d = 16'(pidInput);
      `DSR_ADDR_PID_OUTPUT: d = 16'(pidOutput);
      `DSR_ADDR_CPU_SW: d = cpuSoftwareNumber;
      `DSR_ADDR_FLASH_SW: d = flashSoftwareNumber;
      `DSR_ADDR_COMM_ERR: d = errDetail;
      `DSR_ADDR_POWER_RATING: d = powerRating;
      `DSR_ADDR_CONTROL_METHOD: d = controlMethod;
      default: d = 16'h0000;
    endcase
    return d;
  endfunction

  // ******************************
  // next state
  // ******************************
  always_comb begin
    dsr_pkg::dsr_kind_e kind;
    logic [15:0] off;
    logic [IDX_W-1:0] pIdx;
    logic [7:0] code;
    logic [15:0] data;
    kind = decodeKind(reqAddr);
    off = reqAddr - `DSR_ADDR_PARAM_BASE;
    pIdx = off[IDX_W-1:0];
    code = `DSR_CODE_NONE;
    data = 16'h0000;
    st_next = st_reg;
    st_next.rspValid = 1'b0;
    st_next.faultPulse = faultResetIn;
    st_next.eepromWe = 1'b0;
    startNv = 1'b0;
    startRam = 1'b0;

    // commit walk: copy one staged word per cycle into the active set
    if (copyEn) begin
      st_next.active[copyIdx] = st_reg.stage[copyIdx];
      st_next.eepromWe = toEeprom;
      st_next.eepromAddr = copyIdx;
      st_next.eepromData = st_reg.stage[copyIdx];
    end

    if (reqValid) begin
      if (reqWrite && reqBroadcast && kind != dsr_pkg::KIND_OP
          && kind != dsr_pkg::KIND_FREQ) begin
        // broadcast beyond the operation block is not executed
        code = `DSR_CODE_BAD_ADDR;
      end else if (reqWrite) begin
        unique case (kind)
          dsr_pkg::KIND_OP: begin
            st_next.opReg = reqWdata;
            if (reqWdata[`DSR_OP_FAULT_RESET]) begin
              st_next.faultPulse = 1'b1;
            end
          end
          dsr_pkg::KIND_FREQ: begin
            st_next.freqReg = reqWdata;
          end
          dsr_pkg::KIND_PARAM: begin
            // staging is frozen while the walk reads it
            if (busy) begin
              code = `DSR_CODE_BUSY;
            end else begin
              st_next.stage[pIdx] = reqWdata;
            end
          end
          dsr_pkg::KIND_COMMIT_NV, dsr_pkg::KIND_COMMIT_RAM: begin
            if (reqWdata != `DSR_COMMIT_VALUE) begin
              code = `DSR_CODE_BAD_DATA;
            end else if (busy) begin
              code = `DSR_CODE_BUSY;
            end else begin
              startNv = (kind == dsr_pkg::KIND_COMMIT_NV);
              startRam = (kind == dsr_pkg::KIND_COMMIT_RAM);
            end
          end
          dsr_pkg::KIND_MON: begin
            code = `DSR_CODE_WRITE_MODE;
          end
          dsr_pkg::KIND_NONE: begin
            code = `DSR_CODE_BAD_ADDR;
          end
        endcase
      end else begin
        unique case (kind)
          dsr_pkg::KIND_OP: data = st_reg.opReg;
          dsr_pkg::KIND_FREQ: data = st_reg.freqReg;
          dsr_pkg::KIND_MON: data = monRead(reqAddr);
          dsr_pkg::KIND_PARAM: data = st_reg.stage[pIdx];
          dsr_pkg::KIND_COMMIT_NV, dsr_pkg::KIND_COMMIT_RAM: begin
            code = `DSR_CODE_BAD_ADDR;
          end
          dsr_pkg::KIND_NONE: code = `DSR_CODE_BAD_ADDR;
        endcase
      end
      // broadcast writes to operation and frequency run; all broadcast writes stay silent and leave the last answer standing
      st_next.rspValid = !(reqWrite && reqBroadcast);
      if (st_next.rspValid) begin
        st_next.rspCode = code;
        st_next.rspData = (code == `DSR_CODE_NONE) ? data : 16'h0000;
      end
    end

    // defined bits from the broadcast word, the rest from the local node
    st_next.opMerged = (st_next.opReg & `DSR_OP_DEFINED_MASK)
                     | (localOpSignal & ~`DSR_OP_DEFINED_MASK);
  end

  // ******************************
  // registers
  // ******************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.opReg <= `DSR_OP_RESET;
      st_reg.freqReg <= `DSR_FREQ_RESET;
      st_reg.stage <= {PARAM_DEPTH{`DSR_PARAM_RESET}};
      st_reg.active <= {PARAM_DEPTH{`DSR_PARAM_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ******************************
  // helpers
  // ******************************
  // error latch cleared by the registered fault reset pulse
  dsr_err_latch u_err (
    .clk(clk),
    .rst(rst),
    .errEvent(commErrEvent),
    .clear(st_reg.faultPulse),
    .errDetail(errDetail)
  );

  // commit walker
  dsr_commit_ctrl #(
    .DEPTH(PARAM_DEPTH),
    .IDX_W(IDX_W)
  ) u_commit (
    .clk(clk),
    .rst(rst),
    .startNv(startNv),
    .startRam(startRam),
    .busy(busy),
    .copyEn(copyEn),
    .copyIdx(copyIdx),
    .toEeprom(toEeprom),
    .done(walkDone)
  );

  // ******************************
  // outputs
  // ******************************
  assign rspValid = st_reg.rspValid;
  assign rspData = st_reg.rspData;
  assign rspErrorCode = st_reg.rspCode;
  assign rspError = (st_reg.rspCode != `DSR_CODE_NONE);
  assign opSignal = st_reg.opMerged;
  assign runCommand = st_reg.opMerged[`DSR_OP_RUN];
  assign reverseCommand = st_reg.opMerged[`DSR_OP_REVERSE];
  assign externalFault = st_reg.opMerged[`DSR_OP_EXT_FAULT];
  assign faultResetCommand = st_reg.faultPulse;
  assign digitalInputFiveToEight = st_reg.opMerged[`DSR_OP_DIN_LSB +: 4];
  assign frequencyReference = st_reg.freqReg;
  assign paramActive = st_reg.active;
  assign commitBusy = busy;
  assign commitDone = walkDone;
  assign eepromWrite = st_reg.eepromWe;
  assign eepromAddr = st_reg.eepromAddr;
  assign eepromData = st_reg.eepromData;

endmodule

// ### tb/dsr_register_map_chk.sv
// port assertions for the drive serial register map
// assumes the bind below and a commit depth of four words
`timescale 1ns/100ps
`include "dsr_regs.svh"

module dsr_register_map_chk #(
  parameter int PARAM_DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic clk, rst, reqValid, reqWrite, reqBroadcast, rspValid,
  input wire logic runCommand, reverseCommand, externalFault, faultResetCommand,
  input wire logic commitBusy, commitDone, eepromWrite,
  input wire logic [15:0] reqAddr, reqWdata, rspData, localOpSignal, opSignal,
  input wire logic [7:0] rspErrorCode,
  input wire logic [3:0] transistorOutput, digitalInputFiveToEight
);
  // **********
  // helpers
  // **********
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // operation register write, broadcast or not
  wire opWr = reqValid && reqWrite && reqAddr == `DSR_ADDR_OP_SIGNAL;
  // commit that must start: zero value, idle walker, addressed write
  wire cmtGo = reqValid && reqWrite && !reqBroadcast && !commitBusy && reqWdata == 16'h0000;
  wire cmtNv = cmtGo && reqAddr == `DSR_ADDR_COMMIT_NV;
  wire cmtRam = cmtGo && reqAddr == `DSR_ADDR_COMMIT_RAM;
  wire rdCmt = reqValid && !reqWrite &&
    (reqAddr == `DSR_ADDR_COMMIT_NV || reqAddr == `DSR_ADDR_COMMIT_RAM);
  // **********
  // assertions
  // **********
  bcast_silent_a:
    assert property (reqValid && reqWrite && reqBroadcast |=> !rspValid && $stable(rspErrorCode))
    else $error("broadcast write was answered");
  dout_read_a:
    assert property (reqValid && !reqWrite && reqAddr == `DSR_ADDR_DOUT_STATUS
      |=> rspData == {11'h000, $past(transistorOutput), 1'b0} && rspErrorCode == 8'h00)
    else $error("output status word wrong");
  commit_read_a:
    assert property (rdCmt |=> rspValid && rspErrorCode == `DSR_CODE_BAD_ADDR)
    else $error("commit register read not refused");
  local_bits_a:
    assert property (!$past(rst) |-> ((opSignal ^ $past(localOpSignal))
      & ~`DSR_OP_DEFINED_MASK) == 16'h0000)
    else $error("undefined bits not from local node");
  cmd_map_a:
    assert property ({runCommand, reverseCommand, externalFault, digitalInputFiveToEight}
      == {opSignal[0], opSignal[1], opSignal[4], opSignal[15:12]})
    else $error("command outputs differ from operation word");
  op_write_a:
    assert property (opWr |=> ((opSignal ^ $past(reqWdata)) & `DSR_OP_DEFINED_MASK) == 16'h0000)
    else $error("operation write not applied");
  fault_cmd_a:
    assert property (opWr && reqWdata[5] |=> faultResetCommand)
    else $error("fault reset command missing");
  commit_start_a:
    assert property (cmtNv || cmtRam |=> commitBusy && rspErrorCode == 8'h00)
    else $error("commit did not start");
  ram_only_a:
    assert property (cmtRam |=> !eepromWrite [*6])
    else $error("eeprom written by ram commit");
  nv_store_a:
    assert property (cmtNv |-> ##2 eepromWrite [*3] ##1 (eepromWrite && commitDone))
    else $error("eeprom store sequence wrong");
endmodule

bind dsr_register_map dsr_register_map_chk #(
  .PARAM_DEPTH(PARAM_DEPTH), .IDX_W(IDX_W)) u_chk (
  .clk(clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqBroadcast(reqBroadcast), .rspValid(rspValid), .runCommand(runCommand),
  .reverseCommand(reverseCommand), .externalFault(externalFault),
  .faultResetCommand(faultResetCommand), .commitBusy(commitBusy), .commitDone(commitDone),
  .eepromWrite(eepromWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspData(rspData),
  .localOpSignal(localOpSignal), .opSignal(opSignal), .rspErrorCode(rspErrorCode),
  .transistorOutput(transistorOutput), .digitalInputFiveToEight(digitalInputFiveToEight)
);

// ### tb/dsr_plc_model.sv
// serial bus master model: one register access per call
// assumes the caller collects answers elsewhere
`timescale 1ns/100ps
`include "dsr_regs.svh"

module dsr_plc_model (
  input wire logic clk,
  output logic reqValid,
  output logic reqWrite,
  output logic reqBroadcast,
  output logic [15:0] reqAddr,
  output logic [15:0] reqWdata
);
  int nvCommits = 0; // eeprom commits issued, kept to a handful
  // **********
  // idle bus
  // **********
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqBroadcast = 1'b0;
    reqAddr = 16'hFFFF;
    reqWdata = 16'hFFFF;
  end
  // one-cycle strobe; released fields show the inverse so stale values never match
  task automatic access(input logic wr, bc, input logic [15:0] a, d);
    @(posedge clk);
    #1;
    if (wr && a == `DSR_ADDR_COMMIT_NV && d == `DSR_COMMIT_VALUE) nvCommits++;
    reqValid = 1'b1;
    reqWrite = wr;
    reqBroadcast = bc;
    reqAddr = a;
    reqWdata = d;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    reqAddr = ~a;
    reqWdata = ~d;
  endtask
endmodule

// ### tb/dsr_register_map_tb_top.sv
// self-checking bench for the drive serial register map
// assumes the checker is bound and the master model issues requests
`timescale 1ns/100ps
`include "dsr_regs.svh"

module dsr_register_map_tb_top;
  localparam int DEPTH = 4; // short walker keeps commits quick
  logic clk, rspValid, rspError, run, rev, extFault, faultCmd, busy, done, eeWr;
  logic reqValid, reqWrite, reqBroadcast;
  logic rst = 1'b1;
  logic powerSel = 1'b0;
  logic faultIn = 1'b0;
  logic [5:0] errEv = 6'h00;
  logic [3:0] tOut = 4'h0;
  logic [3:0] din;
  logic [1:0] eeAddr;
  logic [7:0] rspCode;
  logic [15:0] reqAddr, reqWdata, rspData, opSignal, freqRef, eeData, v, op, errExp;
  logic [15:0] localOp = 16'h0000;
  logic [15:0] rnd = 16'h0057; // lfsr state
  logic [15:0] mon[10]; // monitor inputs
  logic [15:0] pv[DEPTH]; // staged words
  logic [DEPTH*16-1:0] active, actExp;
  logic [23:0] notes[$]; // expected data and code
  int errors = 0;
  int n_compared = 0;
  int eeCount = 0;
  // **********
  // design and master
  // **********
  dsr_plc_model pm (.clk(clk), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqBroadcast(reqBroadcast), .reqAddr(reqAddr), .reqWdata(reqWdata));
  dsr_register_map #(.PARAM_DEPTH(DEPTH), .IDX_W(2)) DUT (
    .clk(clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqBroadcast(reqBroadcast), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .rspValid(rspValid), .rspData(rspData), .rspError(rspError), .rspErrorCode(rspCode),
    .transistorOutput(tOut), .dcBusVoltage(mon[0]), .torqueValue(mon[1]),
    .outputPowerValue(mon[2]), .outputPowerDisplayItem(powerSel), .pidFeedback(mon[3]),
    .pidInput(mon[4]), .pidOutput(mon[5]), .cpuSoftwareNumber(mon[6]),
    .flashSoftwareNumber(mon[7]), .powerRating(mon[8]), .controlMethod(mon[9]),
    .commErrEvent(errEv), .faultResetIn(faultIn), .localOpSignal(localOp),
    .opSignal(opSignal), .runCommand(run), .reverseCommand(rev), .externalFault(extFault),
    .faultResetCommand(faultCmd), .digitalInputFiveToEight(din),
    .frequencyReference(freqRef), .paramActive(active), .commitBusy(busy),
    .commitDone(done), .eepromWrite(eeWr), .eepromAddr(eeAddr), .eepromData(eeData));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // **********
  // helpers
  // **********
  function automatic logic [15:0] nx();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, got);
    n_compared++;
    if (exp !== got) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [15:0] a, d, input logic [7:0] c);
    notes.push_back({d, c});
    pm.access(1'b0, 1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [15:0] a, d, input logic [7:0] c);
    notes.push_back({16'h0000, c});
    pm.access(1'b1, 1'b0, a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // stage words, refuse bad and busy writes, commit, compare
  task automatic commit(input logic [15:0] a, input int ee);
    int n;
    for (int i = 0; i < DEPTH; i++) begin
      pv[i] = nx();
      wr(`DSR_ADDR_PARAM_BASE + 16'(i), pv[i], 8'h00);
    end
    rd(`DSR_ADDR_PARAM_BASE + 16'h0002, pv[2], 8'h00);
    chk("staged not active", actExp, active);
    eeCount = 0;
    wr(a, 16'h0001, `DSR_CODE_BAD_DATA);
    wr(a, `DSR_COMMIT_VALUE, 8'h00);
    wr(`DSR_ADDR_PARAM_BASE, 16'h5A5A, `DSR_CODE_BUSY);
    for (n = 0; n < 40; n++) begin
      cyc(1);
      if (done === 1'b1) break;
    end
    if (n == 40) begin
      errors++;
      $display("MISMATCH commit done expected 1 seen timeout");
      tally_and_finish();
    end
    cyc(2);
    actExp = {pv[3], pv[2], pv[1], pv[0]};
    chk("active after commit", actExp, active);
    chk("eeprom words", ee, eeCount);
  endtask
  // answer and eeprom watcher: oldest note against each answer
  always @(posedge clk) begin
    if (rspValid === 1'b1 && notes.size() == 0) chk("unasked answer", 0, 1);
    if (rspValid === 1'b1 && notes.size() != 0) begin
      chk("answer", {notes[0], |notes[0][7:0]}, {rspData, rspCode, rspError});
      void'(notes.pop_front());
    end
    if (eeWr === 1'b1) begin
      eeCount++;
      chk("eeprom word", pv[eeAddr], eeData);
    end
  end
  // **********
  // main sequence
  // **********
  initial begin
    foreach (mon[i]) mon[i] = nx();
    actExp = '0;
    cyc(2);
    rst = 1'b0;
    for (int k = 0; k < 4; k++) begin
      foreach (mon[i]) mon[i] = nx();
      tOut = mon[0][3:0];
      powerSel = mon[1][0];
      rd(`DSR_ADDR_DOUT_STATUS, {11'h000, tOut, 1'b0}, 8'h00);
      rd(`DSR_ADDR_DC_BUS, mon[0], 8'h00);
      rd(`DSR_ADDR_TORQUE_POWER, mon[powerSel ? 2 : 1], 8'h00);
      for (int j = 0; j < 3; j++) rd(`DSR_ADDR_PID_FEEDBACK + 16'(j), mon[3 + j], 8'h00);
      for (int j = 0; j < 2; j++) rd(`DSR_ADDR_CPU_SW + 16'(j), mon[6 + j], 8'h00);
      for (int j = 0; j < 2; j++) rd(`DSR_ADDR_POWER_RATING + 16'(j), mon[8 + j], 8'h00);
    end
    rd(16'h0035, 16'h0000, `DSR_CODE_BAD_ADDR);
    wr(`DSR_ADDR_DC_BUS, 16'h1234, `DSR_CODE_WRITE_MODE);
    $display("test done: monitors");
    errExp = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      errEv = 6'h01 << i;
      cyc(1);
      errEv = 6'h00;
      errExp[i < 2 ? i : i + 1] = 1'b1;
      rd(`DSR_ADDR_COMM_ERR, errExp, 8'h00);
    end
    faultIn = 1'b1;
    cyc(1);
    faultIn = 1'b0;
    cyc(2);
    rd(`DSR_ADDR_COMM_ERR, 16'h0000, 8'h00);
    errEv = 6'h08;
    cyc(1);
    errEv = 6'h00;
    wr(`DSR_ADDR_OP_SIGNAL, 16'h0020, 8'h00);
    cyc(2);
    rd(`DSR_ADDR_COMM_ERR, 16'h0000, 8'h00);
    $display("test done: error details");
    for (int k = 0; k < 3; k++) begin
      localOp = nx();
      v = nx();
      wr(`DSR_ADDR_OP_SIGNAL, v, 8'h00);
      rd(`DSR_ADDR_OP_SIGNAL, v, 8'h00);
      op = (v & `DSR_OP_DEFINED_MASK) | (localOp & ~`DSR_OP_DEFINED_MASK);
      chk("operation word", {op, op[0], op[1], op[4], op[15:12]},
        {opSignal, run, rev, extFault, din});
      v = nx();
      wr(`DSR_ADDR_FREQ_REF, v, 8'h00);
      rd(`DSR_ADDR_FREQ_REF, v, 8'h00);
      chk("frequency reference", v, freqRef);
      v = nx();
      pm.access(1'b1, 1'b1, `DSR_ADDR_OP_SIGNAL, v);
      pm.access(1'b1, 1'b1, `DSR_ADDR_DC_BUS, v);
      cyc(1);
      chk("broadcast operation", v & 16'hF033, opSignal & 16'hF033);
    end
    $display("test done: operation signal");
    commit(`DSR_ADDR_COMMIT_RAM, 0);
    commit(`DSR_ADDR_COMMIT_NV, DEPTH);
    $display("test done: parameter commit");
    rd(`DSR_ADDR_COMMIT_NV, 16'h0000, `DSR_CODE_BAD_ADDR);
    rd(`DSR_ADDR_COMMIT_RAM, 16'h0000, `DSR_CODE_BAD_ADDR);
    cyc(4);
    chk("pending answers", 0, notes.size());
    chk("eeprom commits", 1, pm.nvCommits);
    $display("test done: write-only commit");
    tally_and_finish();
  end
endmodule
